// >>> inc/ccl_consts.vh
`ifndef CCL_CONSTS_VH
`define CCL_CONSTS_VH

// Byte 1 field positions
`define CCL_B1_PWR_BIT 7
`define CCL_B1_ADDR_HI 6
`define CCL_B1_ADDR_LO 3
`define CCL_B1_READ_BIT 2
`define CCL_B1_TWO_BYTE_BIT 1

// Register address codes (byte 1 bits 6..3)
`define CCL_ADDR_MODE 4'h0
`define CCL_ADDR_LATCH_VAL 4'h1
`define CCL_ADDR_LATCH_DIR 4'h2

// Mode register field positions
`define CCL_MODE_CLK_HI 7
`define CCL_MODE_CLK_LO 6
`define CCL_MODE_LAW 5
`define CCL_MODE_INV 4
`define CCL_MODE_TIMING 3
`define CCL_MODE_DLOOP 2
`define CCL_MODE_ALOOP 1
`define CCL_MODE_AMP_PD 0

// Clock-select codes
`define CCL_CLK_512K 2'h0
`define CCL_CLK_1M5 2'h1
`define CCL_CLK_2M048 2'h2
`define CCL_CLK_4M096 2'h3

// Reset values
`define CCL_MODE_RESET 8'h89
`define CCL_LATCH_DIR_RESET 8'h00
`define CCL_LATCH_VAL_RESET 8'h00
`define CCL_PWR_DOWN_RESET 1'b1

// Latch geometry
`define CCL_NUM_PINS 4
`define CCL_LATCH_TOP 7

// Serial port
`define CCL_BITS_PER_BYTE 3'h7

`endif

// >>> core/ccl_ser_shift.v
`timescale 1ns/1ps
`include "ccl_consts.vh"

module ccl_ser_shift (
	input wire mclk,
	input wire rst_n,
	input wire cs_n,
	input wire ctrl_clock,
	input wire ctrl_serial_in,
	input wire load_en,
	input wire [7:0] load_byte,
	output reg [7:0] rx_byte,
	output reg rx_done,
	output wire abort,
	output reg ctrl_serial_out,
	output wire ctrl_serial_out_oe
);
	reg ctrl_clock_q;
	reg [2:0] bit_cnt;
	reg [6:0] in_sh;
	reg [7:0] out_sh;
	reg out_active;
	wire fall;
	wire rise;

	assign fall = ctrl_clock_q & ~ctrl_clock;
	assign rise = ~ctrl_clock_q & ctrl_clock;
	// Byte cut short by chip select
	assign abort = cs_n & (bit_cnt != 3'h0);
	assign ctrl_serial_out_oe = ~cs_n & out_active;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_clock_q <= 1'b0;
			bit_cnt <= 3'h0;
			in_sh <= 7'h00;
			rx_byte <= 8'h00;
			rx_done <= 1'b0;
		end else begin
			ctrl_clock_q <= ctrl_clock;
			rx_done <= 1'b0;
			if (cs_n) begin
				bit_cnt <= 3'h0;
			end else if (fall) begin
				// MSB arrives first
				in_sh <= {in_sh[5:0], ctrl_serial_in};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == `CCL_BITS_PER_BYTE) begin
					rx_byte <= {in_sh, ctrl_serial_in};
					rx_done <= 1'b1;
				end
			end
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_sh <= 8'h00;
			out_active <= 1'b0;
			ctrl_serial_out <= 1'b0;
		end else if (load_en) begin
			out_sh <= load_byte;
			out_active <= 1'b1;
		end else if (cs_n ? abort : (fall && bit_cnt == `CCL_BITS_PER_BYTE)) begin
			out_active <= 1'b0;
		end else if (!cs_n && rise && out_active) begin
			ctrl_serial_out <= out_sh[7];
			out_sh <= {out_sh[6:0], 1'b0};
		end
	end
endmodule // ccl_ser_shift

// >>> core/ccl_regs.v
// What this block does
// - Clock-select bits choose internal master divider
// - Reset gives 2.048MHz, mu-law, non-delayed, normal
// - Law and inversion bits choose companding
// - Bit 3 selects delayed or non-delayed timing
// - Loop bits pick normal, digital or analog
// - Analog loop isolates input, feeds output back
// - Digital loop returns received byte on transmit
// - Decoding continues during digital loopback
// - Mode register written and read by two-byte instructions
// - Latches are inputs after reset
// - Direction bit per pin, bits 7 to 4
// - Output latches drive their written data bit
// - Input latches sample the external pin level
// - Latch read mixes sensed and programmed levels
// - Data 0 at bit 7 down to bit 2
// - Register loads at eighth clock of byte 2
// - Read data out on rising edges, else released
// - Bit 7 is first on both serial lines
`timescale 1ns/1ps
`include "ccl_consts.vh"

module ccl_regs (
	input wire mclk,
	input wire rst_n,
	input wire cs_n,
	input wire ctrl_clock,
	input wire ctrl_serial_in,
	output wire ctrl_serial_out,
	output wire ctrl_serial_out_oe,
	input wire [3:0] interface_latch_pin_in,
	output reg [3:0] interface_latch_pin_out,
	output reg [3:0] interface_latch_pin_oe,
	input wire [7:0] rx_pcm_byte,
	input wire [7:0] enc_pcm_byte,
	output reg [7:0] pcm_tx_out,
	output reg [1:0] clk_sel,
	output reg [3:0] clk_rate_onehot,
	output reg law_mu,
	output reg law_a_inverted,
	output reg law_a_plain,
	output reg timing_select,
	output reg digital_loop_en,
	output reg analog_loop_en,
	output reg tx_analog_in_isolate,
	output reg rx_analog_out_loop_feed,
	output reg rx_analog_out_enable,
	output reg rx_decode_enable,
	output reg rx_amp_enable,
	output reg powered_down_state,
	output reg [7:0] channel_mode_control,
	output reg [7:0] latch_direction
);
	localparam ST_BYTE1 = 2'b01;
	localparam ST_BYTE2 = 2'b10;

	reg [1:0] state;
	reg [3:0] pend_addr;
	reg pend_read;
	reg [7:0] latch_data_bits;
	reg load_en;
	reg [7:0] load_byte;
	reg [7:0] latch_values;
	reg [1:0] next_state;
	wire [7:0] rx_byte;
	wire rx_done;
	wire abort;
	wire [3:0] b1_addr;
	integer i;
	integer j;

	ccl_ser_shift u_shift (
		.mclk(mclk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.ctrl_clock(ctrl_clock),
		.ctrl_serial_in(ctrl_serial_in),
		.load_en(load_en),
		.load_byte(load_byte),
		.rx_byte(rx_byte),
		.rx_done(rx_done),
		.abort(abort),
		.ctrl_serial_out(ctrl_serial_out),
		.ctrl_serial_out_oe(ctrl_serial_out_oe)
	);

	assign b1_addr = rx_byte[`CCL_B1_ADDR_HI:`CCL_B1_ADDR_LO];

	// Read view of latch values: pin level for inputs, stored for outputs
	always @* begin
		latch_values = latch_data_bits;
		for (i = 0; i < `CCL_NUM_PINS; i = i + 1) begin
			if (!latch_direction[`CCL_LATCH_TOP - i]) begin
				latch_values[`CCL_LATCH_TOP - i] = interface_latch_pin_in[i];
			end
		end
		latch_values[1:0] = 2'b00;
	end

	// Byte sequencing
	always @* begin
		next_state = state;
		load_en = 1'b0;
		load_byte = 8'h00;
		case (state)
			ST_BYTE1: begin
				if (rx_done && rx_byte[`CCL_B1_TWO_BYTE_BIT]) begin
					next_state = ST_BYTE2;
					if (rx_byte[`CCL_B1_READ_BIT]) begin
						load_en = 1'b1;
						if (b1_addr == `CCL_ADDR_MODE) begin
							load_byte = channel_mode_control;
						end else if (b1_addr == `CCL_ADDR_LATCH_VAL) begin
							load_byte = latch_values;
						end else if (b1_addr == `CCL_ADDR_LATCH_DIR) begin
							load_byte = latch_direction;
						end else begin
							load_byte = 8'h00;
						end
					end
				end
			end
			ST_BYTE2: begin
				if (abort || rx_done) begin
					next_state = ST_BYTE1;
				end
			end
			default: begin
				next_state = ST_BYTE1;
			end
		endcase
		if (abort) begin
			next_state = ST_BYTE1;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_BYTE1;
			pend_addr <= 4'h0;
			pend_read <= 1'b0;
			powered_down_state <= `CCL_PWR_DOWN_RESET;
			channel_mode_control <= `CCL_MODE_RESET;
			latch_direction <= `CCL_LATCH_DIR_RESET;
			latch_data_bits <= `CCL_LATCH_VAL_RESET;
		end else begin
			state <= next_state;
			if (state == ST_BYTE1 && rx_done) begin
				powered_down_state <= rx_byte[`CCL_B1_PWR_BIT];
				pend_addr <= b1_addr;
				pend_read <= rx_byte[`CCL_B1_READ_BIT];
			end
			// Write lands only when the eighth bit of byte 2 is taken
			if (state == ST_BYTE2 && rx_done && !abort && !pend_read) begin
				if (pend_addr == `CCL_ADDR_MODE) begin
					channel_mode_control <= rx_byte;
				end else if (pend_addr == `CCL_ADDR_LATCH_VAL) begin
					latch_data_bits <= {rx_byte[7:2], 2'b00};
				end else if (pend_addr == `CCL_ADDR_LATCH_DIR) begin
					latch_direction <= {rx_byte[7:2], 2'b00};
				end
			end
		end
	end

	// Latch pins and mode decode
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			interface_latch_pin_out <= 4'h0;
			interface_latch_pin_oe <= 4'h0;
			clk_sel <= `CCL_CLK_2M048;
			clk_rate_onehot <= 4'h4;
			law_mu <= 1'b1;
			law_a_inverted <= 1'b0;
			law_a_plain <= 1'b0;
			timing_select <= 1'b1;
			digital_loop_en <= 1'b0;
			analog_loop_en <= 1'b0;
			tx_analog_in_isolate <= 1'b0;
			rx_analog_out_loop_feed <= 1'b0;
			rx_analog_out_enable <= 1'b1;
			rx_decode_enable <= 1'b1;
			rx_amp_enable <= 1'b0;
			pcm_tx_out <= 8'h00;
		end else begin
			for (j = 0; j < `CCL_NUM_PINS; j = j + 1) begin
				interface_latch_pin_oe[j] <= latch_direction[`CCL_LATCH_TOP - j];
				interface_latch_pin_out[j] <= latch_data_bits[`CCL_LATCH_TOP - j];
			end
			clk_sel <= {channel_mode_control[`CCL_MODE_CLK_HI],
				channel_mode_control[`CCL_MODE_CLK_LO]};
			case ({channel_mode_control[`CCL_MODE_CLK_HI],
				channel_mode_control[`CCL_MODE_CLK_LO]})
				`CCL_CLK_512K: begin
					clk_rate_onehot <= 4'h1;
				end
				`CCL_CLK_1M5: begin
					clk_rate_onehot <= 4'h2;
				end
				`CCL_CLK_2M048: begin
					clk_rate_onehot <= 4'h4;
				end
				default: begin
					clk_rate_onehot <= 4'h8;
				end
			endcase
			law_mu <= ~channel_mode_control[`CCL_MODE_LAW];
			law_a_inverted <= channel_mode_control[`CCL_MODE_LAW]
				& ~channel_mode_control[`CCL_MODE_INV];
			law_a_plain <= channel_mode_control[`CCL_MODE_LAW]
				& channel_mode_control[`CCL_MODE_INV];
			timing_select <= channel_mode_control[`CCL_MODE_TIMING];
			digital_loop_en <= channel_mode_control[`CCL_MODE_DLOOP];
			analog_loop_en <= ~channel_mode_control[`CCL_MODE_DLOOP]
				& channel_mode_control[`CCL_MODE_ALOOP];
			tx_analog_in_isolate <= ~channel_mode_control[`CCL_MODE_DLOOP]
				& channel_mode_control[`CCL_MODE_ALOOP];
			rx_analog_out_loop_feed <= ~channel_mode_control[`CCL_MODE_DLOOP]
				& channel_mode_control[`CCL_MODE_ALOOP];
			// Receive path never cut by loop modes
			rx_analog_out_enable <= 1'b1;
			rx_decode_enable <= 1'b1;
			rx_amp_enable <= ~(powered_down_state
				& channel_mode_control[`CCL_MODE_AMP_PD]);
			if (channel_mode_control[`CCL_MODE_DLOOP]) begin
				pcm_tx_out <= rx_pcm_byte;
			end else begin
				pcm_tx_out <= enc_pcm_byte;
			end
		end
	end
endmodule // ccl_regs

// >>> bench/ccl_regs_checker.sv
`timescale 1ns/1ps
module ccl_regs_checker (
	input wire mclk,
	input wire rst_n,
	input wire cs_n,
	input wire ctrl_serial_out_oe,
	input wire [3:0] interface_latch_pin_oe,
	input wire [7:0] rx_pcm_byte,
	input wire [7:0] enc_pcm_byte,
	input wire [7:0] pcm_tx_out,
	input wire [3:0] clk_rate_onehot,
	input wire law_mu,
	input wire law_a_inverted,
	input wire law_a_plain,
	input wire digital_loop_en,
	input wire analog_loop_en,
	input wire rx_amp_enable,
	input wire powered_down_state,
	input wire [7:0] channel_mode_control,
	input wire [7:0] latch_direction,
	input wire [1:0] clk_sel,
	input wire timing_select,
	input wire tx_analog_in_isolate,
	input wire rx_analog_out_loop_feed,
	input wire rx_analog_out_enable,
	input wire rx_decode_enable
);
	reg [7:0] pm, prx, pen;
	reg [3:0] pdr;
	reg pr, ppd, pdl;
	// Previous-cycle copies
	always @(posedge mclk) begin
		pm <= channel_mode_control;
		prx <= rx_pcm_byte;
		pen <= enc_pcm_byte;
		pdr <= {latch_direction[4], latch_direction[5], latch_direction[6], latch_direction[7]};
		pr <= rst_n;
		ppd <= powered_down_state;
		pdl <= digital_loop_en;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_oe_cs; cs_n |-> !ctrl_serial_out_oe; endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("serial out driven while deselected");
	property p_clk; pr |-> clk_rate_onehot == (4'h1 << pm[7:6]); endproperty
	a_clk: assert property (p_clk) else $error("clock select decode wrong");
	property p_law; pr |-> {law_mu, law_a_inverted, law_a_plain} ==
		(!pm[5] ? 3'h4 : (pm[4] ? 3'h1 : 3'h2)); endproperty
	a_law: assert property (p_law) else $error("law decode wrong");
	property p_loops; pr |-> {digital_loop_en, analog_loop_en} == {pm[2], !pm[2] && pm[1]}; endproperty
	a_loops: assert property (p_loops) else $error("loop decode wrong");
	property p_tx; pr && digital_loop_en == pdl |-> pcm_tx_out == (pdl ? prx : pen); endproperty
	a_tx: assert property (p_tx) else $error("transmit byte source wrong");
	property p_amp; pr |-> rx_amp_enable == !(ppd && pm[0]); endproperty
	a_amp: assert property (p_amp) else $error("amplifier enable wrong");
	property p_dir; pr |-> interface_latch_pin_oe == pdr; endproperty
	a_dir: assert property (p_dir) else $error("latch pin enable wrong");
	property p_wr; $changed(channel_mode_control) || $changed(latch_direction) |->
		!$past(cs_n, 2); endproperty
	a_wr: assert property (p_wr) else $error("register changed outside a transfer");
	property p_tim; pr |-> clk_sel == pm[7:6] && timing_select == pm[3]; endproperty
	a_tim: assert property (p_tim) else $error("timing or clock select wrong");
	property p_aloop; pr |-> tx_analog_in_isolate == (!pm[2] && pm[1]) &&
		rx_analog_out_loop_feed == (!pm[2] && pm[1]) && rx_analog_out_enable; endproperty
	a_aloop: assert property (p_aloop) else $error("analog loop path wrong");
	property p_rxon; pr && digital_loop_en |-> rx_decode_enable && rx_analog_out_enable;
	endproperty
	a_rxon: assert property (p_rxon) else $error("receive path cut in digital loop");
	property p_rst; !pr |-> channel_mode_control == 8'h89 && latch_direction == 8'h00 &&
		interface_latch_pin_oe == 4'h0 && powered_down_state && !rx_amp_enable; endproperty
	a_rst: assert property (p_rst) else $error("state after reset wrong");
endmodule // ccl_regs_checker

bind ccl_regs ccl_regs_checker chk (.mclk, .rst_n, .cs_n, .ctrl_serial_out_oe,
	.interface_latch_pin_oe, .rx_pcm_byte, .enc_pcm_byte, .pcm_tx_out, .clk_rate_onehot,
	.law_mu, .law_a_inverted, .law_a_plain, .digital_loop_en, .analog_loop_en,
	.rx_amp_enable, .powered_down_state, .channel_mode_control, .latch_direction,
	.clk_sel, .timing_select, .tx_analog_in_isolate, .rx_analog_out_loop_feed,
	.rx_analog_out_enable, .rx_decode_enable);

// >>> bench/ccl_ctrl_model.sv
`timescale 1ns/1ps
module ccl_ctrl_model (
	input wire mclk,
	input wire ctrl_serial_out,
	input wire ctrl_serial_out_oe,
	output logic cs_n,
	output logic ctrl_clock,
	output logic ctrl_serial_in
);
	initial begin
		cs_n = 1'b1;
		ctrl_clock = 1'b0;
		ctrl_serial_in = 1'b0;
	end
	// Read bit taken late in the high phase, before the fall ends the byte
	task automatic shift(input logic [7:0] b, input int w, input int n, inout logic [7:0] q);
		for (int i = 7; i > 7 - n; i--) begin
			@(posedge mclk);
			ctrl_serial_in <= b[i];
			ctrl_clock <= 1'b1;
			repeat (w - 1) @(posedge mclk);
			@(negedge mclk);
			q[i] = ctrl_serial_out_oe ? ctrl_serial_out : 1'bx;
			@(posedge mclk);
			ctrl_clock <= 1'b0;
			repeat (w - 1) @(posedge mclk);
		end
	endtask
	task automatic frame(input logic [7:0] b1, b2, input int w, n, output logic [7:0] q);
		@(posedge mclk);
		cs_n <= 1'b0;
		shift(b1, w, n > 8 ? 8 : n, q);
		if (b1[1] && n > 8) shift(b2, w, n - 8, q);
		@(posedge mclk);
		cs_n <= 1'b1;
		ctrl_serial_in <= ~ctrl_serial_in; // Released line shows no stale level
	endtask
endmodule // ccl_ctrl_model

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0, rst_n = 1'b0, pb;
	logic [7:0] rx_b = 8'h00, enc_b = 8'h00, q, em, ev, ed;
	logic [3:0] ext = 4'h0;
	wire [3:0] po, poe;
	wire [3:0] pin = (poe & po) | (~poe & ext);
	wire cs_n, cck, csi, cso, cso_oe, pd;
	wire [7:0] cmc, ldir;
	int fails = 0, tests_run = 0, seed = 29, w;
	always #25 mclk = ~mclk;
	always @(posedge mclk) {rx_b, enc_b} <= 16'($random(seed));
	ccl_ctrl_model ctl (.mclk(mclk), .ctrl_serial_out(cso), .ctrl_serial_out_oe(cso_oe),
		.cs_n(cs_n), .ctrl_clock(cck), .ctrl_serial_in(csi));
	ccl_regs dut (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .ctrl_clock(cck),
		.ctrl_serial_in(csi), .ctrl_serial_out(cso), .ctrl_serial_out_oe(cso_oe),
		.interface_latch_pin_in(pin), .interface_latch_pin_out(po),
		.interface_latch_pin_oe(poe), .rx_pcm_byte(rx_b), .enc_pcm_byte(enc_b),
		.pcm_tx_out(), .clk_sel(), .clk_rate_onehot(), .law_mu(), .law_a_inverted(),
		.law_a_plain(), .timing_select(), .digital_loop_en(), .analog_loop_en(),
		.tx_analog_in_isolate(), .rx_analog_out_loop_feed(), .rx_analog_out_enable(),
		.rx_decode_enable(), .rx_amp_enable(), .powered_down_state(pd),
		.channel_mode_control(cmc), .latch_direction(ldir));
	task chk(input string n, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", n, e, g);
			fails++;
		end
	endtask
	// Inputs sensed, outputs as programmed, low two bits zero
	function automatic logic [7:0] lat(input logic [7:0] v, d, input logic [3:0] x);
		lat = {v[7:2] & {d[7:4], 2'h3} | {x[0], x[1], x[2], x[3], 2'h0} & ~{d[7:4], 2'h3}, 2'h0};
	endfunction
	task tally_and_finish;
		if (fails == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#3_000_000;
		fails++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		ctl.frame(8'h86, 8'h00, 2, 16, q); chk("mode", 8'h89, q);
		ctl.frame(8'h96, 8'h00, 2, 16, q); chk("dir", 8'h00, q);
		chk("pin_oe", 8'h00, {4'h0, poe});
		ctl.frame(8'hbe, 8'h00, 2, 16, q); chk("unmapped", 8'h00, q);
		for (int i = 0; i < 12; i++) begin
			w = 2 + ($random(seed) & 2);
			pb = 1'($random(seed));
			em = i == 0 ? 8'h00 : (i == 1 ? 8'hff : 8'($random(seed)));
			ctl.frame({pb, 7'h02}, em, w, 16, q);
			ctl.frame({pb, 7'h06}, 8'h00, w, 16, q); chk("mode_rd", em, q);
			chk("mode_reg", em, cmc);
			ctl.frame({~pb, 7'h00}, 8'h00, w, 8, q);
			repeat (3) @(posedge mclk);
			chk("power", {7'h0, ~pb}, {7'h0, pd});
			ev = 8'($random(seed));
			ed = 8'($random(seed)) | 8'h0c;
			ctl.frame(8'h0a, ev, w, 16, q);
			ctl.frame(8'h12, ed, w, 16, q);
			ext <= 4'($random(seed));
			ctl.frame(8'h0e, 8'h00, w, 16, q); chk("latch_rd", lat(ev, ed, ext), q);
			chk("dir_reg", {ed[7:2], 2'h0}, ldir);
			chk("pin_oe", {4'h0, ed[4], ed[5], ed[6], ed[7]}, {4'h0, poe});
			chk("pin_out", {4'h0, ev[4], ev[5], ev[6], ev[7]}, {4'h0, po});
		end
		ctl.frame(8'h02, ~em, 2, 12, q);
		ctl.frame(8'h06, 8'h00, 2, 16, q); chk("after_abort", em, q);
		// Reset again in mid-run
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		ctl.frame(8'h86, 8'h00, 2, 16, q); chk("mode_rst", 8'h89, q);
		chk("pin_oe_rst", 8'h00, {4'h0, poe});
		// Write to an unmapped address is ignored
		ctl.frame(8'h3a, 8'h55, 2, 16, q);
		repeat (3) @(posedge mclk);
		chk("mode_kept", 8'h89, cmc);
		chk("dir_kept", 8'h00, ldir);
		ctl.frame(8'h0a, 8'hf0, 2, 16, q);
		// Unconnected pins all made outputs
		ctl.frame(8'h12, 8'hfc, 2, 16, q);
		repeat (3) @(posedge mclk);
		chk("pin_oe_all", 8'h0f, {4'h0, poe});
		chk("pin_out_all", 8'h0f, {4'h0, po});
		// Controller's master clock taken as 4.096 MHz
		ctl.frame(8'h02, 8'hc9, 2, 16, q);
		ctl.frame(8'h06, 8'h00, 2, 16, q); chk("mode_clk", 8'hc9, q);
		tally_and_finish;
	end
endmodule // testbench
